// >>> verification/kbd_mouse_model.sv
// Purpose: keyboard, mouse and panel switch seen from the block
// Assumes: driven from aclk, changes just after rising edges
// Notes: key data is inverted once released so no stale byte lingers
`timescale 1ns/1ps
module kbd_mouse_model (
    // clock
    input wire logic aclk,
    // toward the block
    output logic kbd_valid,
    output logic [7:0] kbd_data,
    output logic mouse_wake_event,
    output logic panel_switch_input
);
    // idle levels from time zero
    initial begin
        kbd_valid = 1'h0;
        kbd_data = 8'h00;
        mouse_wake_event = 1'h0;
        panel_switch_input = 1'h0;
    end
    // one byte per high cycle of valid
    task automatic send_key(input logic [7:0] b);
        @(posedge aclk);
        kbd_valid <= 1'h1;
        kbd_data <= b;
        @(posedge aclk);
        kbd_valid <= 1'h0;
        kbd_data <= ~b;
    endtask
    // one-cycle wake pulse
    task automatic mouse_click();
        @(posedge aclk);
        mouse_wake_event <= 1'h1;
        @(posedge aclk);
        mouse_wake_event <= 1'h0;
    endtask
    // held long enough to pass the pin synchronisers
    task automatic press_panel();
        @(posedge aclk);
        panel_switch_input <= 1'h1;
        repeat (6) @(posedge aclk);
        panel_switch_input <= 1'h0;
    endtask
endmodule

// >>> verification/wakeup_event_power_loss_regs_bench.sv
// Purpose: register-level tests of the wake-up bank over axi4-lite
// Assumes: byte address is four times the index
// Notes: pin events need three edges, so waits are six
`timescale 1ns/1ps
module wakeup_event_power_loss_regs_bench;
    import wake_pkg::*;
    logic aclk, aresetn, battery_reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic standby_supply, main_power_ok, thermal_shutdown, panel_switch_input, host_bus_reset_n;
    logic kbd_valid, mouse_wake_event, power_on_request, wake_hunting, irq, seen, on;
    logic [7:0] kbd_data, d;
    logic [7:0] ki[3] = '{8'h00, 8'h3e, 8'h4e};
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    wakeup_event_power_loss_regs i_wakeup_event_power_loss_regs (.*);
    kbd_mouse_model i_kbd_mouse_model (.*);
    // 8 ns clock
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    // hang guard and capture of the one-cycle power-on pulse
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (power_on_request === 1'h1) seen <= 1'h1;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // both write channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] i);
        @(posedge aclk);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        rd(i);
        chk($sformatf("reg %h", i), e, d);
    endtask
    task automatic standby_cycle();
        standby_supply <= 1'h0;
        repeat (6) @(posedge aclk);
        standby_supply <= 1'h1;
        repeat (8) @(posedge aclk);
    endtask
    initial begin
        {aresetn, battery_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, main_power_ok, thermal_shutdown} = 4'h0;
        {standby_supply, host_bus_reset_n, seen} = 3'h6;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'h1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        battery_reset_n <= 1'h1;
        rc(IDX_EVENT_STATUS, 8'h08);
        rc(IDX_EVENT_STATUS, 8'h00);
        rc(IDX_KEY_INDEX, 8'h00);
        rc(IDX_CONTROL, 8'h00);
        rd(8'h00);
        chk("unmapped resp", {6'h00, RESP_SLVERR}, {6'h00, r});
        wr(8'h00, 8'h00);
        chk("unmapped bresp", {6'h00, RESP_SLVERR}, {6'h00, r});
        $display("test reset done");
        // each stored set: all ones first, then the written byte
        for (int i = 0; i < 3; i++) begin
            wr(IDX_KEY_INDEX, ki[i]);
            rc(IDX_KEY_DATA, 8'hff);
            wr(IDX_KEY_DATA, ki[i] ^ 8'h5a);
            wr(IDX_KEY_INDEX, ki[i]);
            rc(IDX_KEY_DATA, ki[i] ^ 8'h5a);
        end
        $display("test key sets done");
        wr(IDX_CONTROL, 8'h0c);
        chk("hunting", 8'h01, {7'h00, wake_hunting});
        i_kbd_mouse_model.send_key(8'h55);
        repeat (2) @(posedge aclk);
        rc(IDX_CONTROL, 8'h08);
        chk("hunting off", 8'h00, {7'h00, wake_hunting});
        rc(IDX_EVENT_STATUS, 8'h01);
        wr(IDX_KEY_INDEX, 8'h1e);
        rc(IDX_KEY_DATA, 8'h55);
        host_bus_reset_n <= 1'h0;
        repeat (6) @(posedge aclk);
        host_bus_reset_n <= 1'h1;
        rc(IDX_CONTROL, 8'h00);
        // programmed match on set one: 5a then fourteen ff, oldest first
        for (int k = 0; k < KEY_LEN; k++) i_kbd_mouse_model.send_key(k == 0 ? 8'h5a : 8'hff);
        repeat (2) @(posedge aclk);
        rc(IDX_EVENT_STATUS, 8'h01);
        $display("test keyboard wake done");
        wr(IDX_IRQ_MASK, 8'h02);
        thermal_shutdown <= 1'h1;
        i_kbd_mouse_model.mouse_click();
        i_kbd_mouse_model.press_panel();
        chk("irq", 8'h01, {7'h00, irq});
        rc(IDX_EVENT_STATUS, 8'h0e);
        rc(IDX_EVENT_STATUS, 8'h00);
        wr(IDX_IRQ_STATUS, 8'h02);
        chk("irq cleared", 8'h00, {7'h00, irq});
        $display("test events done");
        // qualifier on, last state flag 0, main power seen off before loss
        wr(IDX_RECOVERY_CFG, 8'h01);
        for (int p = 0; p < 4; p++) begin
            wr(IDX_CONTROL, {1'h0, 2'(p), 5'h00});
            rc(IDX_CONTROL, {1'h0, 2'(p), 5'h00});
            seen = 1'h0;
            standby_cycle();
            on = 1'(p % 2);
            chk("power on", {7'h00, on}, {7'h00, seen});
            rc(IDX_EVENT_STATUS, on ? 8'h20 : 8'h30);
        end
        $display("test power loss done");
        wrap_up();
    end
endmodule

// >>> verilog/wake_pkg.sv
// Purpose: shared constants and types for the wake-up event and power-loss register bank
// Assumes: registers are reached by index; byte address is four times the index
// Notes: bit positions, reset values and index windows live here only
package wake_pkg;
    // key storage shape
    localparam int KEY_LEN = 15;
    localparam int KEY_SETS = 3;
    localparam int SLOT_W = 6;
    // register indices
    localparam logic [7:0] IDX_KEY_INDEX = 8'he1;
    localparam logic [7:0] IDX_KEY_DATA = 8'he2;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'he3;
    localparam logic [7:0] IDX_CONTROL = 8'he4;
    localparam logic [7:0] IDX_RECOVERY_CFG = 8'he8;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hf8;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf9;
    // reset values
    localparam logic [7:0] RST_KEY_INDEX = 8'h00;
    localparam logic [7:0] RST_KEY_DATA = 8'hff;
    localparam logic [5:0] RST_EVENT_STATUS = 6'h08;
    localparam logic [7:0] RST_KEY_BUF = 8'h00;
    // event status bit positions
    localparam int EV_W = 6;
    localparam int EV_STANDBY = 5;
    localparam int EV_POWER_STATE = 4;
    localparam int EV_THERMAL = 3;
    localparam int EV_PANEL = 2;
    localparam int EV_MOUSE = 1;
    localparam int EV_KEYBOARD = 0;
    // control and recovery config bit positions
    localparam int CTL_POLICY_HI = 6;
    localparam int CTL_POLICY_LO = 5;
    localparam int CTL_ANY_KEY = 3;
    localparam int CTL_HUNT = 2;
    localparam int CFG_QUALIFIER = 0;
    localparam int CFG_LAST_STATE = 4;
    // index windows by high nibble; low nibble 0..e is valid
    localparam logic [3:0] NIB_SET1 = 4'h0;
    localparam logic [3:0] NIB_BUF = 4'h1;
    localparam logic [3:0] NIB_SET2 = 4'h3;
    localparam logic [3:0] NIB_SET3 = 4'h4;
    localparam logic [3:0] NIB_INVALID = 4'hf;
    localparam logic [5:0] SLOT_SET1 = 6'h00;
    localparam logic [5:0] SLOT_SET2 = 6'h0f;
    localparam logic [5:0] SLOT_SET3 = 6'h1e;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // power-loss recovery policy
    typedef enum logic [1:0] {
        POLICY_OFF = 2'b00,
        POLICY_ON = 2'b01,
        POLICY_PREVIOUS = 2'b10,
        POLICY_USER = 2'b11
    } loss_policy_t;
    // pins after synchronisation
    typedef struct packed {
        logic standby_ok;
        logic main_power_ok;
        logic thermal;
        logic panel_switch;
        logic host_reset_n;
    } pins_t;
    // decoded index
    typedef struct packed {
        logic hit_set;
        logic hit_buf;
        logic [5:0] slot;
    } key_map_t;
endpackage

// >>> verilog/wakeup_event_power_loss_regs.sv
// Purpose: wake-up key storage, event status, power-loss policy and interrupt behind AXI4-Lite
// Assumes: aresetn is the standby-supply reset, battery_reset_n the battery reset, both same clock
// Notes: keyboard bytes and mouse events come from logic on aclk; supply and switch pins are synchronised
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module wakeup_event_power_loss_regs
    import wake_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic battery_reset_n,
    // axi4-lite write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // asynchronous pins
    input wire logic standby_supply,
    input wire logic main_power_ok,
    input wire logic thermal_shutdown,
    input wire logic panel_switch_input,
    input wire logic host_bus_reset_n,
    // same-clock event sources
    input wire logic kbd_valid,
    input wire logic [7:0] kbd_data,
    input wire logic mouse_wake_event,
    // outputs
    output logic power_on_request,
    output logic wake_hunting,
    output logic irq
);
    // two-stage synchronisers, then one stage for edge history
    pins_t pin_meta, pin_sync, pin_prev;
    pins_t pin_raw;
    assign pin_raw = '{standby_supply, main_power_ok, thermal_shutdown, panel_switch_input, host_bus_reset_n};

    always_ff @(posedge aclk) begin
        pin_meta <= pin_raw;
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end

    // bus state
    logic aw_held, w_held, bvalid, rvalid;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [EV_W-1:0] rd_clear;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid, next_w_lane0;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [7:0] next_w_data;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [EV_W-1:0] next_rd_clear;

    // register state
    logic [7:0] key_index, next_key_index;
    logic [EV_W-1:0] ev_status, next_ev_status, ev_set;
    logic any_key, hunting, qualifier, next_any_key, next_hunting, next_qualifier;
    logic [EV_W-1:0] irq_status, irq_mask, next_irq_status, next_irq_mask;
    logic [7:0] key_mem [0:KEY_SETS*KEY_LEN-1];
    logic [7:0] next_key_mem [0:KEY_SETS*KEY_LEN-1];
    logic [7:0] kbuf [0:KEY_LEN-1];
    logic [7:0] next_kbuf [0:KEY_LEN-1];
    // battery domain
    loss_policy_t policy, next_policy;
    logic last_state_flag, prev_on, next_last_state_flag, next_prev_on;
    // recovery and matching
    logic decide, turn_on, next_power_on_request, kbd_shifted, match_any;
    logic [KEY_SETS-1:0] set_match;

    // decode an index into a storage slot
    function automatic key_map_t map_index(input logic [7:0] idx);
        key_map_t m;
        m = '{1'b0, 1'b0, SLOT_SET1};
        if (idx[3:0] != NIB_INVALID) begin
            case (idx[7:4])
                NIB_SET1: m = '{1'b1, 1'b0, SLOT_SET1 + {2'b00, idx[3:0]}};
                NIB_SET2: m = '{1'b1, 1'b0, SLOT_SET2 + {2'b00, idx[3:0]}};
                NIB_SET3: m = '{1'b1, 1'b0, SLOT_SET3 + {2'b00, idx[3:0]}};
                NIB_BUF: m = '{1'b0, 1'b1, {2'b00, idx[3:0]}};
                default: m = '{1'b0, 1'b0, SLOT_SET1};
            endcase
        end
        return m;
    endfunction

    key_map_t cur_map;
    logic [7:0] key_read;
    logic do_write, wr_in_range, rd_in_range, rd_fire;
    logic [7:0] wr_idx, rd_idx;
    assign cur_map = map_index(key_index);
    assign key_read = cur_map.hit_set ? key_mem[cur_map.slot] :
                      cur_map.hit_buf ? kbuf[cur_map.slot[3:0]] : RST_KEY_DATA;
    assign wr_idx = aw_addr[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign wr_in_range = (aw_addr[ADDR_W-1:10] == '0) && (aw_addr[1:0] == 2'b00);
    assign rd_in_range = (s_axi_araddr[ADDR_W-1:10] == '0) && (s_axi_araddr[1:0] == 2'b00);
    assign do_write = aw_held && w_held && !bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // ready outputs are combinational; valid and data outputs are registered
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign wake_hunting = hunting;
    assign irq = |(irq_status & irq_mask);

    // read-side mux; the bus block below captures which status bits a read will clear
    logic [7:0] rd_byte;
    logic rd_known;
    always_comb begin
        rd_byte = 8'h00;
        rd_known = 1'b1;
        case (rd_idx)
            IDX_KEY_INDEX: rd_byte = key_index;
            IDX_KEY_DATA: rd_byte = key_read;
            IDX_EVENT_STATUS: begin
                rd_byte = {2'b00, ev_status};
                rd_byte[EV_POWER_STATE] = ev_status[EV_POWER_STATE] & qualifier;
            end
            IDX_CONTROL: begin
                rd_byte[CTL_POLICY_HI:CTL_POLICY_LO] = policy;
                rd_byte[CTL_ANY_KEY] = any_key;
                rd_byte[CTL_HUNT] = hunting;
            end
            IDX_RECOVERY_CFG: begin
                rd_byte[CFG_QUALIFIER] = qualifier;
                rd_byte[CFG_LAST_STATE] = last_state_flag;
            end
            IDX_IRQ_STATUS: rd_byte = {2'b00, irq_status};
            IDX_IRQ_MASK: rd_byte = {2'b00, irq_mask};
            default: rd_known = 1'b0;
        endcase
    end

    // bus channel next state
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_rd_clear = rd_clear;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata[7:0];
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_in_range && (wr_idx inside {IDX_KEY_INDEX, IDX_KEY_DATA, IDX_EVENT_STATUS,
                IDX_CONTROL, IDX_RECOVERY_CFG, IDX_IRQ_STATUS, IDX_IRQ_MASK}) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rdata = (rd_in_range && rd_known) ? {24'h000000, rd_byte} : 32'h00000000;
            next_rresp = (rd_in_range && rd_known) ? RESP_OKAY : RESP_SLVERR;
            // every set status bit gets cleared, including a power-state bit the read returned as 0 with the qualifier off
            next_rd_clear = (rd_in_range && rd_idx == IDX_EVENT_STATUS) ? ev_status : '0;
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_rd_clear = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
            rd_clear <= '0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            rd_clear <= next_rd_clear;
        end
    end

    logic wr_ok;
    assign wr_ok = do_write && wr_in_range && w_lane0;

    // keyboard match: buffer holds last bytes, oldest at slot 0
    always_comb begin
        for (int k = 0; k < KEY_SETS; k++) begin
            set_match[k] = 1'b1;
            for (int j = 0; j < KEY_LEN; j++) begin
                if (kbuf[j] != key_mem[k*KEY_LEN+j]) begin
                    set_match[k] = 1'b0;
                end
            end
        end
        match_any = kbd_shifted && (|set_match);
    end

    // recovery decision on standby return
    assign decide = pin_sync.standby_ok && !pin_prev.standby_ok;
    always_comb begin
        case (policy)
            POLICY_OFF: turn_on = 1'b0;
            POLICY_ON: turn_on = 1'b1;
            POLICY_PREVIOUS: turn_on = prev_on;
            POLICY_USER: turn_on = !last_state_flag;
            default: turn_on = 1'b0;
        endcase
    end

    // event sources
    always_comb begin
        ev_set = '0;
        ev_set[EV_STANDBY] = decide;
        ev_set[EV_POWER_STATE] = decide && !turn_on;
        ev_set[EV_THERMAL] = pin_sync.thermal && !pin_prev.thermal;
        ev_set[EV_PANEL] = pin_sync.panel_switch && !pin_prev.panel_switch;
        ev_set[EV_MOUSE] = mouse_wake_event;
        ev_set[EV_KEYBOARD] = (kbd_valid && any_key) || (match_any && !any_key);
    end

    // standby-domain registers next state
    always_comb begin
        next_key_index = key_index;
        next_key_mem = key_mem;
        next_kbuf = kbuf;
        next_any_key = any_key;
        next_hunting = hunting;
        next_qualifier = qualifier;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status | ev_set;
        next_power_on_request = decide && turn_on;
        // set wins over the read that clears
        next_ev_status = (ev_status & ~(rvalid && s_axi_rready ? rd_clear : '0)) | ev_set;
        if (kbd_valid) begin
            for (int j = 0; j < KEY_LEN - 1; j++) begin
                next_kbuf[j] = kbuf[j+1];
            end
            next_kbuf[KEY_LEN-1] = kbd_data;
        end
        if (wr_ok) begin
            case (wr_idx)
                IDX_KEY_INDEX: next_key_index = w_data;
                IDX_KEY_DATA: begin
                    // buffer window is read-only; writes there are dropped
                    if (cur_map.hit_set) begin
                        next_key_mem[cur_map.slot] = w_data;
                    end
                end
                IDX_CONTROL: begin
                    next_any_key = w_data[CTL_ANY_KEY];
                    next_hunting = w_data[CTL_HUNT];
                end
                IDX_RECOVERY_CFG: next_qualifier = w_data[CFG_QUALIFIER];
                IDX_IRQ_STATUS: next_irq_status = (irq_status & ~w_data[EV_W-1:0]) | ev_set;
                IDX_IRQ_MASK: next_irq_mask = w_data[EV_W-1:0];
                default: ;
            endcase
        end
        // a captured wake event ends hunting even against a same-cycle write
        if (|ev_set[EV_PANEL:EV_KEYBOARD]) begin
            next_hunting = 1'b0;
        end
        if (!pin_sync.host_reset_n) begin
            next_any_key = 1'b0;
            next_hunting = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_index <= RST_KEY_INDEX;
            ev_status <= RST_EVENT_STATUS;
            any_key <= 1'b0;
            hunting <= 1'b0;
            qualifier <= 1'b0;
            irq_status <= '0;
            irq_mask <= '0;
            power_on_request <= 1'b0;
            kbd_shifted <= 1'b0;
            for (int i = 0; i < KEY_SETS*KEY_LEN; i++) begin
                key_mem[i] <= RST_KEY_DATA;
            end
            for (int j = 0; j < KEY_LEN; j++) begin
                kbuf[j] <= RST_KEY_BUF;
            end
        end else begin
            key_index <= next_key_index;
            ev_status <= next_ev_status;
            any_key <= next_any_key;
            hunting <= next_hunting;
            qualifier <= next_qualifier;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            power_on_request <= next_power_on_request;
            kbd_shifted <= kbd_valid;
            key_mem <= next_key_mem;
            kbuf <= next_kbuf;
        end
    end

    // battery domain; prev_on follows main power only while standby is up,
    // so a platform that drops main before standby records off
    always_comb begin
        next_policy = policy;
        next_last_state_flag = last_state_flag;
        next_prev_on = pin_sync.standby_ok ? pin_sync.main_power_ok : prev_on;
        if (wr_ok && wr_idx == IDX_CONTROL) begin
            next_policy = loss_policy_t'(w_data[CTL_POLICY_HI:CTL_POLICY_LO]);
        end
        if (wr_ok && wr_idx == IDX_RECOVERY_CFG) begin
            next_last_state_flag = w_data[CFG_LAST_STATE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!battery_reset_n) begin
            policy <= POLICY_OFF;
            last_state_flag <= 1'b0;
            prev_on <= 1'b0;
        end else begin
            policy <= next_policy;
            last_state_flag <= next_last_state_flag;
            prev_on <= next_prev_on;
        end
    end

    // checks
    property p_index_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_ok && wr_idx == IDX_KEY_INDEX |=> key_index == $past(w_data);
    endproperty
    a_index_write: assert property (p_index_write) else $error("index write lost");

    property p_read_clears;
        @(posedge aclk) disable iff (!aresetn)
        rvalid && s_axi_rready && ev_set == '0 |=> (ev_status & $past(rd_clear)) == '0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

    property p_set_wins;
        @(posedge aclk) disable iff (!aresetn)
        ev_set != '0 |=> (ev_status & $past(ev_set)) == $past(ev_set);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost");

    property p_thermal;
        @(posedge aclk) disable iff (!aresetn)
        pin_sync.thermal && !pin_prev.thermal |=> ev_status[EV_THERMAL];
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal event not latched");

    property p_policy_on;
        @(posedge aclk) disable iff (!aresetn || !battery_reset_n)
        decide && policy == POLICY_ON |=> power_on_request ##1 !power_on_request;
    endproperty
    a_policy_on: assert property (p_policy_on) else $error("policy on did not request power");

    property p_policy_off;
        @(posedge aclk) disable iff (!aresetn || !battery_reset_n)
        decide && policy == POLICY_OFF |=> !power_on_request && ev_status[EV_POWER_STATE];
    endproperty
    a_policy_off: assert property (p_policy_off) else $error("policy off misbehaved");

    property p_policy_user;
        @(posedge aclk) disable iff (!aresetn || !battery_reset_n)
        decide && policy == POLICY_USER |=> power_on_request == !$past(last_state_flag);
    endproperty
    a_policy_user: assert property (p_policy_user) else $error("user last state ignored");

    property p_hunt_clear;
        @(posedge aclk) disable iff (!aresetn)
        ev_set[EV_PANEL:EV_KEYBOARD] != '0 |=> !hunting;
    endproperty
    a_hunt_clear: assert property (p_hunt_clear) else $error("hunting not cleared");

    property p_any_key;
        @(posedge aclk) disable iff (!aresetn)
        kbd_valid && any_key |=> ev_status[EV_KEYBOARD];
    endproperty
    a_any_key: assert property (p_any_key) else $error("any key did not wake");

    property p_mouse;
        @(posedge aclk) disable iff (!aresetn)
        mouse_wake_event && !rd_fire && !rvalid |=> ev_status[EV_MOUSE] [*2];
    endproperty
    a_mouse: assert property (p_mouse) else $error("mouse wake not held");
endmodule
